//--- cfg_pkg.sv
/*
 * shared constants and carriers for the serial configuration interpreter.
 * assumes a 50 MHz system clock and an 8N1 host serial link.
 */
package cfg_pkg;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned CHAR_TMO_MS   = 10;
    localparam int unsigned CHAR_TMO_CYC  = CLK_HZ / 1000 * CHAR_TMO_MS;
    localparam int unsigned BAUD_4800     = 4800;
    localparam int unsigned BAUD_9600     = 9600;
    localparam int unsigned BAUD_19200    = 19200;
    localparam int unsigned BAUD_38400    = 38400;
    localparam logic [15:0] DIV_4800      = 16'(CLK_HZ / BAUD_4800);
    localparam logic [15:0] DIV_9600      = 16'(CLK_HZ / BAUD_9600);
    localparam logic [15:0] DIV_19200     = 16'(CLK_HZ / BAUD_19200);
    localparam logic [15:0] DIV_38400     = 16'(CLK_HZ / BAUD_38400);
    localparam int unsigned DATA_BITS     = 8;

    // -------------------------------------------------------------
    // configuration image layout
    // -------------------------------------------------------------
    localparam int unsigned NUM_CFG       = 12;
    localparam logic [3:0]  OFS_DEST0     = 4'h0;
    localparam logic [3:0]  OFS_DEST3     = 4'h3;
    localparam logic [3:0]  OFS_LOCAL0    = 4'h4;
    localparam logic [3:0]  OFS_LOCAL3    = 4'h7;
    localparam logic [3:0]  OFS_CHAN_HI   = 4'h8;
    localparam logic [3:0]  OFS_CHAN_LO   = 4'h9;
    localparam logic [3:0]  OFS_TX_POWER  = 4'hA;
    localparam logic [3:0]  OFS_BIT_RATE  = 4'hB;
    localparam logic [3:0]  LAST_OFS      = 4'hB;
    localparam logic [7:0]  RST_ADDR      = 8'h7E;
    localparam logic [7:0]  RST_CHAN_HI   = 8'h06;
    localparam logic [7:0]  RST_CHAN_LO   = 8'h75;
    localparam logic [7:0]  RST_TX_POWER  = 8'h00;
    localparam logic [7:0]  RST_BIT_RATE  = 8'h23;
    localparam logic [7:0]  MAX_TX_POWER  = 8'h07;
    localparam logic [15:0] CHAN_MIN      = 16'h0060;
    localparam logic [15:0] CHAN_MAX      = 16'h0F3F;
    localparam logic [7:0]  RATE_1200     = 8'hA3;
    localparam logic [7:0]  RATE_2400     = 8'h91;
    localparam logic [7:0]  RATE_4800     = 8'h47;
    localparam logic [7:0]  RATE_9600     = 8'h23;
    localparam logic [7:0]  RATE_19200    = 8'h11;
    localparam logic [7:0]  RATE_38400    = 8'h08;
    localparam logic [7:0]  RATE_57600    = 8'h05;
    localparam logic [7:0]  CHAR_PLUS     = 8'h2B;
    localparam logic [7:0]  CHAR_MINUS    = 8'h2D;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_strobe_t;

    typedef logic [NUM_CFG-1:0][7:0] cfg_image_t;
endpackage

//--- uart_rx.sv
/*
 * 8N1 serial receiver with selectable bit period.
 * assumes the line input is already synchronous to sys_clk_i.
 */
`timescale 1ns/1ns
module uart_rx (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [15:0]          bit_div_i,
    input  wire logic                 line_i,
    output cfg_pkg::byte_strobe_t     rx_o
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

    rx_state_t             st_q, st_d;
    logic [15:0]           cnt_q, cnt_d;
    logic [2:0]            bit_q, bit_d;
    logic [7:0]            sh_q, sh_d;
    cfg_pkg::byte_strobe_t out_q, out_d;

    // -------------------------------------------------------------
    // bit sampler
    // -------------------------------------------------------------
    // next state: sample mid-bit, flag byte on valid stop bit
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q + 16'h0001;
        bit_d = bit_q;
        sh_d  = sh_q;
        out_d = '{valid: 1'b0, data: out_q.data};
        case (st_q)
            RX_IDLE: begin
                cnt_d = 16'h0000;
                if (!line_i) begin
                    st_d = RX_START;
                end
            end
            RX_START: begin
                if (cnt_q == {1'b0, bit_div_i[15:1]}) begin
                    cnt_d = 16'h0000;
                    bit_d = 3'h0;
                    st_d  = line_i ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (cnt_q == bit_div_i - 16'h0001) begin // one bit is bit_div_i cycles
                    cnt_d = 16'h0000;
                    sh_d  = {line_i, sh_q[7:1]}; // lsb first
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'(cfg_pkg::DATA_BITS - 1)) begin
                        st_d = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (cnt_q == bit_div_i - 16'h0001) begin
                    st_d  = RX_IDLE;
                    out_d = '{valid: line_i, data: sh_q};
                end
            end
            default: st_d = RX_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q  <= RX_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 3'h0;
            sh_q  <= 8'h00;
            out_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sh_q  <= sh_d;
            out_q <= out_d;
        end
    end

    assign rx_o = out_q;
endmodule // uart_rx

//--- uart_tx.sv
/*
 * 8N1 serial transmitter with selectable bit period.
 * assumes the caller waits for ready before strobing a byte.
 */
`timescale 1ns/1ns
module uart_tx (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [15:0]          bit_div_i,
    input  cfg_pkg::byte_strobe_t     tx_i,
    output logic                      ready_o,
    output logic                      line_o
);
    logic [9:0]  frm_q, frm_d;
    logic [3:0]  left_q, left_d;
    logic [15:0] cnt_q, cnt_d;
    logic        line_q, line_d;

    // -------------------------------------------------------------
    // shifter
    // -------------------------------------------------------------
    // next state: load frame when idle, shift one bit per period
    always_comb begin
        frm_d  = frm_q;
        left_d = left_q;
        cnt_d  = cnt_q;
        line_d = line_q;
        if (left_q == 4'h0) begin
            line_d = 1'b1;
            if (tx_i.valid) begin
                frm_d  = {1'b1, tx_i.data, 1'b0};
                left_d = 4'hA;
                cnt_d  = 16'h0000;
                line_d = 1'b0;
            end
        end else if (cnt_q == bit_div_i - 16'h0001) begin // one bit is bit_div_i cycles
            cnt_d  = 16'h0000;
            frm_d  = {1'b1, frm_q[9:1]};
            left_d = left_q - 4'h1;
            line_d = (left_q == 4'h1) ? 1'b1 : frm_q[1];
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    // state registers
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frm_q  <= 10'h3FF;
            left_q <= 4'h0;
            cnt_q  <= 16'h0000;
            line_q <= 1'b1;
        end else begin
            frm_q  <= frm_d;
            left_q <= left_d;
            cnt_q  <= cnt_d;
            line_q <= line_d;
        end
    end

    // ready from state only, so a caller may strobe on ready without a loop
    assign ready_o = (left_q == 4'h0);
    assign line_o  = line_q;
endmodule // uart_tx

//--- serial_config_interpreter.sv
/*
 * configuration-mode command interpreter of a serial radio modem.
 * assumes synchronous host pins and an rf datapath that takes packet
 * bytes and reports received destination addresses.
 */
// How it works
// RL1: three plus chars enter configuration mode
// RL2: entering config replies with current image
// RL3: three minus chars leave, no reply
// RL4: tx power codes 0..7, 3 dB steps
// RL5: only seven listed bit rate codes accepted
// RL6: host computes channel from frequency formula
// RL7: bytes 8 and 9 form channel
// RL8: channel limited to 96..3903 inclusive
// RL9: channel needs both bytes in write
// RL10: image echoed after each config packet
// RL11: unsent trailing bytes keep old values
// RL12: commit on rts high or silence timeout
// RL13: zero destination restores factory defaults
// RL14: pass rf packet only on address match
// RL15: short address write keeps stored address
// RL16: illegal power or rate code ignored
// RL17: hosts swap local addresses as destinations
// RL18: 8N1 link, rate from select pins
// RL19: persist select chooses nonvolatile store
// RL20: rts low ready, cts high busy
// RL21: bytes fill positions from zero upward
// RL22: config characters never forwarded over rf (the three plus chars that enter config are still forwarded)
`timescale 1ns/1ns
module serial_config_interpreter #(
    parameter int unsigned CLK_HZ   = cfg_pkg::CLK_HZ, // system clock rate, sets bit periods
    parameter int unsigned CHAR_TMO = cfg_pkg::CHAR_TMO_CYC
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 host_txd_i,
    output logic                      host_rxd_o,
    input  wire logic                 host_rts_n_i,
    output logic                      host_cts_n_o,
    input  wire logic                 host_rate_select_lo_i,
    input  wire logic                 host_rate_select_hi_i,
    input  wire logic                 config_persist_select_i,
    input  cfg_pkg::byte_strobe_t     rf_rx_i,
    input  wire logic                 rf_rx_end_i,
    input  wire logic [31:0]          rf_rx_dest_i,
    output cfg_pkg::byte_strobe_t     rf_tx_o,
    output cfg_pkg::cfg_image_t       cfg_o,
    output logic                      config_mode_o,
    output logic                      nv_store_o
);
    typedef enum logic [1:0] {M_DATA, M_CONFIG, M_REPLY} mode_t;

    // -------------------------------------------------------------
    // serial link
    // -------------------------------------------------------------
    logic [15:0]           div_q, div_d;
    cfg_pkg::byte_strobe_t rx_byte, tx_req;
    logic                  tx_ready, txd_line;

    // rate selection, registered every cycle
    always_comb begin
        case ({host_rate_select_hi_i, host_rate_select_lo_i}) // see RL18
            2'b00:   div_d = 16'(CLK_HZ / cfg_pkg::BAUD_4800);
            2'b01:   div_d = 16'(CLK_HZ / cfg_pkg::BAUD_9600);
            2'b10:   div_d = 16'(CLK_HZ / cfg_pkg::BAUD_19200);
            default: div_d = 16'(CLK_HZ / cfg_pkg::BAUD_38400);
        endcase
    end

    uart_rx u_rx (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .bit_div_i (div_q),
        .line_i    (host_txd_i),
        .rx_o      (rx_byte)
    );

    uart_tx u_tx (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .bit_div_i (div_q),
        .tx_i      (tx_req),
        .ready_o   (tx_ready),
        .line_o    (txd_line)
    );

    // -------------------------------------------------------------
    // interpreter state
    // -------------------------------------------------------------
    mode_t                 mode_q, mode_d;
    logic [1:0]            esc_q, esc_d;
    logic [31:0]           tmo_q, tmo_d;
    logic [3:0]            wpos_q, wpos_d;
    logic [3:0]            rpos_q, rpos_d;
    cfg_pkg::cfg_image_t   img_q, img_d;
    cfg_pkg::cfg_image_t   stg_q, stg_d;
    logic                  rts_q, rts_d;
    cfg_pkg::byte_strobe_t rft_q, rft_d;
    logic                  nv_q, nv_d;
    logic                  commit;
    logic [15:0]           chan;
    logic [7:0]            esc_char;

    assign esc_char = (mode_q == M_DATA) ? cfg_pkg::CHAR_PLUS : cfg_pkg::CHAR_MINUS;
    assign chan     = {stg_q[cfg_pkg::OFS_CHAN_HI], stg_q[cfg_pkg::OFS_CHAN_LO]};
    // pending write closes on rts release or silence
    assign commit   = (mode_q == M_CONFIG) && (wpos_q != 4'h0) &&
                      ((host_rts_n_i && !rts_q) || (tmo_q == 32'(CHAR_TMO))); // see RL12

    // legal speed codes only
    function automatic logic rate_ok(input logic [7:0] c);
        rate_ok = (c == cfg_pkg::RATE_1200) || (c == cfg_pkg::RATE_2400) ||
                  (c == cfg_pkg::RATE_4800) || (c == cfg_pkg::RATE_9600) ||
                  (c == cfg_pkg::RATE_19200) || (c == cfg_pkg::RATE_38400) ||
                  (c == cfg_pkg::RATE_57600); // see RL5
    endfunction

    // factory image
    function automatic cfg_pkg::cfg_image_t dflt();
        cfg_pkg::cfg_image_t d;
        d = '0;
        for (int i = 0; i < 8; i++) begin
            d[i] = cfg_pkg::RST_ADDR;
        end
        d[cfg_pkg::OFS_CHAN_HI]  = cfg_pkg::RST_CHAN_HI;
        d[cfg_pkg::OFS_CHAN_LO]  = cfg_pkg::RST_CHAN_LO;
        d[cfg_pkg::OFS_TX_POWER] = cfg_pkg::RST_TX_POWER;
        d[cfg_pkg::OFS_BIT_RATE] = cfg_pkg::RST_BIT_RATE;
        dflt = d;
    endfunction

    // factory image as a constant for the reset branches
    localparam cfg_pkg::cfg_image_t DFLT_IMG = dflt();

    // next state: escape detect, byte capture, commit and reply
    always_comb begin
        mode_d = mode_q;
        esc_d  = esc_q;
        wpos_d = wpos_q;
        rpos_d = rpos_q;
        img_d  = img_q;
        stg_d  = stg_q;
        nv_d   = 1'b0;
        rts_d  = host_rts_n_i;
        tmo_d  = (tmo_q == 32'(CHAR_TMO)) ? tmo_q : tmo_q + 32'h1;
        tx_req = '{valid: 1'b0, data: 8'h00};
        rft_d  = '{valid: 1'b0, data: rft_q.data};
        if (esc_q != 2'h0 && tmo_q == 32'(CHAR_TMO)) begin
            esc_d = 2'h0; // gap too long breaks the escape run
        end
        case (mode_q)
            M_DATA: begin
                if (rx_byte.valid) begin
                    tmo_d = 32'h0;
                    if (rx_byte.data == esc_char) begin
                        esc_d = esc_q + 2'h1;
                        if (esc_q == 2'h2) begin
                            esc_d  = 2'h0;
                            mode_d = M_REPLY; // see RL1
                            rpos_d = 4'h0;
                            wpos_d = 4'h0;
                        end
                    end else begin
                        esc_d = 2'h0;
                    end
                    // only data-mode chars reach the rf side
                    rft_d = rx_byte; // see RL22
                end
                // pass matching rf bytes back to host
                // local address msb sits at position 4
                if (rf_rx_i.valid &&
                    rf_rx_dest_i == {img_q[4], img_q[5], img_q[6], img_q[7]}) begin // see RL14
                    tx_req = rf_rx_i;
                end
            end
            M_CONFIG: begin
                if (commit) begin
                    wpos_d = 4'h0;
                    rpos_d = 4'h0;
                    mode_d = M_REPLY; // see RL10
                    nv_d   = config_persist_select_i; // see RL19
                    // positions past the end keep old values
                    if (wpos_q > cfg_pkg::OFS_DEST3) begin // see RL11
                        img_d[3:0] = stg_q[3:0]; // see RL15
                    end
                    if (wpos_q > cfg_pkg::OFS_LOCAL3) begin
                        img_d[7:4] = stg_q[7:4]; // see RL15
                    end
                    if (wpos_q > cfg_pkg::OFS_CHAN_LO &&
                        chan >= cfg_pkg::CHAN_MIN && chan <= cfg_pkg::CHAN_MAX) begin
                        img_d[9:8] = stg_q[9:8]; // see RL9, RL8, RL7
                    end
                    if (wpos_q > cfg_pkg::OFS_TX_POWER &&
                        stg_q[cfg_pkg::OFS_TX_POWER] <= cfg_pkg::MAX_TX_POWER) begin
                        img_d[cfg_pkg::OFS_TX_POWER] = stg_q[cfg_pkg::OFS_TX_POWER]; // see RL4, RL16
                    end
                    if (wpos_q > cfg_pkg::OFS_BIT_RATE &&
                        rate_ok(stg_q[cfg_pkg::OFS_BIT_RATE])) begin
                        img_d[cfg_pkg::OFS_BIT_RATE] = stg_q[cfg_pkg::OFS_BIT_RATE]; // see RL16
                    end
                    if (wpos_q > cfg_pkg::OFS_DEST3 && stg_q[3:0] == 32'h0) begin
                        img_d = dflt(); // see RL13
                    end
                end else if (rx_byte.valid) begin
                    tmo_d = 32'h0;
                    if (rx_byte.data == esc_char) begin
                        esc_d = esc_q + 2'h1;
                    end else begin
                        esc_d = 2'h0;
                    end
                    if (rx_byte.data == esc_char && esc_q == 2'h2) begin
                        esc_d  = 2'h0;
                        wpos_d = 4'h0;
                        mode_d = M_DATA; // see RL3
                    end else if (wpos_q <= cfg_pkg::LAST_OFS) begin
                        stg_d[wpos_q] = rx_byte.data; // see RL21
                        wpos_d        = wpos_q + 4'h1;
                    end
                end
            end
            M_REPLY: begin
                if (tx_ready) begin
                    tx_req = '{valid: 1'b1, data: img_q[rpos_q]}; // see RL2
                    rpos_d = rpos_q + 4'h1;
                    if (rpos_q == cfg_pkg::LAST_OFS) begin
                        mode_d = M_CONFIG;
                        tmo_d  = 32'h0;
                    end
                end
            end
            default: mode_d = M_DATA;
        endcase
        if (rf_rx_end_i) begin
            rft_d.valid = rft_d.valid;
        end
    end

    // state registers
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= M_DATA;
            esc_q  <= 2'h0;
            tmo_q  <= 32'h0;
            wpos_q <= 4'h0;
            rpos_q <= 4'h0;
            img_q  <= DFLT_IMG;
            stg_q  <= DFLT_IMG;
            rts_q  <= 1'b1;
            rft_q  <= '0;
            nv_q   <= 1'b0;
            div_q  <= 16'(CLK_HZ / cfg_pkg::BAUD_4800);
        end else begin
            mode_q <= mode_d;
            esc_q  <= esc_d;
            tmo_q  <= tmo_d;
            wpos_q <= wpos_d;
            rpos_q <= rpos_d;
            img_q  <= img_d;
            stg_q  <= (mode_q == M_REPLY) ? img_q : stg_d;
            rts_q  <= rts_d;
            rft_q  <= rft_d;
            nv_q   <= nv_d;
            div_q  <= div_d;
        end
    end

    // -------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------
    logic cts_n_q;
    logic rxd_q;
    logic cfg_mode_q;

    // busy while replying or while the transmitter is sending
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cts_n_q    <= 1'b1;
            rxd_q      <= 1'b1;
            cfg_mode_q <= 1'b0;
        end else begin
            cts_n_q    <= (mode_d == M_REPLY) || !tx_ready; // see RL20
            rxd_q      <= txd_line;
            cfg_mode_q <= (mode_d != M_DATA);
        end
    end

    assign host_cts_n_o  = cts_n_q;
    assign host_rxd_o    = rxd_q;
    assign rf_tx_o       = rft_q;
    assign cfg_o         = img_q;
    assign config_mode_o = cfg_mode_q;
    assign nv_store_o    = nv_q;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    sequence s_minus_exit;
        mode_q == M_CONFIG && rx_byte.valid && rx_byte.data == cfg_pkg::CHAR_MINUS
            && esc_q == 2'h2;
    endsequence

    a_exit_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RL3
        s_minus_exit |=> mode_q == M_DATA ##1 mode_q == M_DATA)
        else $error("exit did not return quietly to data mode");
    a_enter_reply: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RL1
        (mode_q == M_DATA && rx_byte.valid && rx_byte.data == cfg_pkg::CHAR_PLUS
         && esc_q == 2'h2) |=> mode_q == M_REPLY)
        else $error("escape did not enter reply");
    a_no_rf_cfg: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RL22
        (mode_q != M_DATA) |=> !rft_q.valid)
        else $error("config byte forwarded to rf");
    a_power_legal: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RL16
        img_q[cfg_pkg::OFS_TX_POWER] <= cfg_pkg::MAX_TX_POWER)
        else $error("illegal power stored");
    a_rate_legal: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RL5
        rate_ok(img_q[cfg_pkg::OFS_BIT_RATE]))
        else $error("illegal rate stored");
    a_chan_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RL8
        {img_q[8], img_q[9]} >= cfg_pkg::CHAN_MIN && {img_q[8], img_q[9]} <= cfg_pkg::CHAN_MAX)
        else $error("channel out of range");
    a_dest_nonzero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RL13
        img_q[3:0] != 32'h0)
        else $error("zero destination stored");
    a_commit_reply: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RL10
        commit |=> mode_q == M_REPLY && rpos_q == 4'h0)
        else $error("commit gave no reply");
endmodule // serial_config_interpreter

//--- host_model.sv
/* host side of the serial link: 8N1 sender and receiver.
   assumes the bit period in clock cycles is given by BIT_CYC. */
`timescale 1ns/1ns
module host_model #(
    parameter int BIT_CYC = 1302
) (
    input  wire logic sys_clk_i,
    output logic      txd_o,
    input  wire logic rxd_i
);
    logic [7:0] rx_q[$];

    // idle line level is high
    initial txd_o = 1'b1;

    // start, eight bits lsb first, stop, one idle bit
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge sys_clk_i);
        for (int i = 0; i < 10; i++) begin
            #2 txd_o = f[i];
            repeat (BIT_CYC) @(posedge sys_clk_i);
        end
        repeat (BIT_CYC) @(posedge sys_clk_i);
    endtask

    // sample each reply bit in mid period
    always begin : capture
        logic [7:0] b;
        @(negedge rxd_i);
        repeat (BIT_CYC / 2) @(posedge sys_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge sys_clk_i);
            b[i] = rxd_i;
        end
        repeat (BIT_CYC) @(posedge sys_clk_i);
        rx_q.push_back(b);
    end
endmodule // host_model

//--- testbench.sv
/* self-checking bench of the configuration interpreter.
   assumes host_model as serial partner at 38400 baud. */
`timescale 1ns/1ns
module testbench;
    localparam int CLK = 614400; // scaled clock rate keeps the run short
    localparam int BIT = CLK / int'(cfg_pkg::BAUD_38400);
    logic                  sys_clk_i;
    logic                  rst_n_i;
    logic                  txd, rxd, cts_n, rts_n, mode, nvs, persist;
    logic [31:0]           dest;
    logic [31:0]           lfsr;
    cfg_pkg::byte_strobe_t rf_rx, rf_tx;
    cfg_pkg::cfg_image_t   cfg;
    logic [7:0]            img[12], b[$];
    logic [7:0]            dflt[12] = '{8'h7E, 8'h7E, 8'h7E, 8'h7E, 8'h7E, 8'h7E, 8'h7E,
                                        8'h7E, 8'h06, 8'h75, 8'h00, 8'h23};
    int                    mismatches = 0, checks = 0, fwd = 0, nvc = 0;

    serial_config_interpreter #(.CLK_HZ(CLK), .CHAR_TMO(25 * BIT)) dut_u (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .host_txd_i(txd), .host_rxd_o(rxd),
        .host_rts_n_i(rts_n), .host_cts_n_o(cts_n), .host_rate_select_lo_i(1'b1),
        .host_rate_select_hi_i(1'b1), .config_persist_select_i(persist), .rf_rx_i(rf_rx),
        .rf_rx_end_i(1'b0), .rf_rx_dest_i(dest), .rf_tx_o(rf_tx), .cfg_o(cfg),
        .config_mode_o(mode), .nv_store_o(nvs));
    host_model #(.BIT_CYC(BIT)) host_u (.sys_clk_i(sys_clk_i), .txd_o(txd), .rxd_i(rxd));

    // count bytes handed to the radio
    always @(posedge sys_clk_i) if (rf_tx.valid === 1'b1) fwd <= fwd + 1;
    // count persistent-store pulses
    always @(posedge sys_clk_i) if (nvs === 1'b1) nvc <= nvc + 1;

    function automatic logic [31:0] lfsr_nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // wait for the image echo and compare it with the model
    task automatic reply();
        for (int n = 0; n < 5000 && host_u.rx_q.size() < 12; n++) @(posedge sys_clk_i);
        repeat (BIT) @(posedge sys_clk_i);
        chk(32'(host_u.rx_q.size()), 32'd12);
        foreach (img[i]) begin
            chk(host_u.rx_q[i], img[i]);
            chk(cfg[i], img[i]);
        end
        host_u.rx_q.delete();
    endtask

    // send a configuration write, update the model, commit, check echo
    task automatic wr(input logic rts);
        foreach (b[i]) host_u.send_byte(b[i]);
        if (b.size() >= 4 && {b[0], b[1], b[2], b[3]} == 32'h0) img = dflt;
        else begin
            for (int k = 0; k < 8; k++) if (b.size() >= k / 4 * 4 + 4) img[k] = b[k];
            if (b.size() >= 10 && {b[8], b[9]} inside {[16'd96:16'd3903]}) begin
                img[8] = b[8];
                img[9] = b[9];
            end
            if (b.size() >= 11 && b[10] <= 8'h07) img[10] = b[10];
            if (b.size() >= 12 && b[11] inside {8'hA3, 8'h91, 8'h47, 8'h23, 8'h11, 8'h08,
                8'h05}) img[11] = b[11];
        end
        if (rts) begin
            @(posedge sys_clk_i);
            #2 rts_n = 1'b1;
            @(posedge sys_clk_i);
            #2 rts_n = 1'b0;
        end
        reply();
    endtask

    // free-running clock
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        mismatches++;
        summarize();
    end

    // main sequence
    initial begin
        rst_n_i = 1'b0;
        rts_n = 1'b0;
        persist = 1'b1;
        rf_rx = '0;
        dest = '0;
        lfsr = 32'hD8D8;
        img = dflt;
        repeat (20) @(posedge sys_clk_i);
        #2 rst_n_i = 1'b1;
        host_u.send_byte(8'h41);
        repeat (10) @(posedge sys_clk_i);
        chk(32'(fwd), 32'd1);
        b = '{8'h2B, 8'h2B, 8'h2B};
        foreach (b[i]) host_u.send_byte(b[i]);
        chk(32'(mode), 32'd1);
        chk(32'(cts_n), 32'd1);
        reply();
        // random write, zero restore, then a second random write
        for (int p = 0; p < 2; p++) begin
            b = {};
            for (int i = 0; i < 12; i++) begin
                lfsr = lfsr_nx(lfsr);
                b.push_back(lfsr[7:0]);
            end
            b[8] = 8'h0F;
            b[9] = 8'h3F;
            b[10] = 8'h09;
            wr(1'b0);
            b = '{8'h00, 8'h00, 8'h00, 8'h00};
            if (p == 0) wr(1'b1);
        end
        #2 persist = 1'b0;
        b = '{8'h00, 8'h00};
        wr(1'b1);
        chk(32'(fwd), 32'd4);
        chk(32'(nvc), 32'd3);
        b = '{8'h2D, 8'h2D, 8'h2D};
        foreach (b[i]) host_u.send_byte(b[i]);
        repeat (1000) @(posedge sys_clk_i);
        chk(32'(mode), 32'd0);
        chk(32'(cts_n), 32'd0);
        chk(32'(host_u.rx_q.size()), 32'd0);
        // one packet for another address, one for ours
        lfsr = lfsr_nx(lfsr);
        #2 dest = ~{img[4], img[5], img[6], img[7]};
        rf_rx = '{1'b1, lfsr[7:0]};
        @(posedge sys_clk_i);
        #2 dest = {img[4], img[5], img[6], img[7]};
        rf_rx = '{1'b1, lfsr[15:8]};
        @(posedge sys_clk_i);
        #2 rf_rx.valid = 1'b0;
        repeat (20 * BIT) @(posedge sys_clk_i);
        chk(32'(host_u.rx_q.size()), 32'd1);
        chk(host_u.rx_q[0], lfsr[15:8]);
        summarize();
    end
endmodule // testbench
